// ### rtl/sl2_regs.svh
// Register offsets, field positions, reset values and geometry of the level 2 cache
`ifndef SL2_REGS_SVH
`define SL2_REGS_SVH
`define SL2_ADDR_W 32
`define SL2_CACHE_BYTES 262144
// Line size: 16, 32, 64 or 128 bytes
`define SL2_LINE_BYTES 64
`define SL2_SUB_BYTES 16
`define SL2_WORD_BYTES 4
`define SL2_APB_AW 12
`define SL2_CTRL_OFF 12'h000
`define SL2_STAT_OFF 12'h004
`define SL2_HITS_OFF 12'h008
`define SL2_MISS_OFF 12'h00c
`define SL2_CTRL_CB_BIT 0
`define SL2_CTRL_WA_BIT 1
`define SL2_CTRL_RST 2'h0
`define SL2_STAT_BUSY_BIT 0
`endif

// ### rtl/sl2_pkg.sv
// Types, derived geometry and address decoding for the level 2 cache
package sl2_pkg;
`include "sl2_regs.svh"
  localparam int ADDR_W = `SL2_ADDR_W;
  localparam int SUBN = `SL2_LINE_BYTES / `SL2_SUB_BYTES;
  localparam int SUB_W = $clog2(SUBN);
  localparam int LINE_WORDS = `SL2_LINE_BYTES / `SL2_WORD_BYTES;
  localparam int BEAT_W = $clog2(LINE_WORDS);
  localparam int WSEL_W = $clog2(`SL2_SUB_BYTES / `SL2_WORD_BYTES);
  localparam int OFF_W = $clog2(`SL2_LINE_BYTES);
  localparam int SUB_LSB = $clog2(`SL2_SUB_BYTES);
  localparam int NLINES = `SL2_CACHE_BYTES / `SL2_LINE_BYTES;
  localparam int IDX_W = $clog2(NLINES);
  localparam int TAG_W = ADDR_W - IDX_W - OFF_W;
  localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(LINE_WORDS - 1);
  localparam logic [WSEL_W-1:0] SUB_LAST = '1;

  typedef enum logic [1:0] {SL2_OP_READ, SL2_OP_WRITE, SL2_OP_DROP} sl2_op_t;
  typedef enum logic [2:0] {
    SL2_INIT, SL2_IDLE, SL2_CHECK, SL2_WB, SL2_FILL, SL2_SEND, SL2_MEMW
  } sl2_state_t;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [SUBN-1:0] valid;
    logic [SUBN-1:0] dirty;
    logic [SUBN-1:0] incl;
  } sl2_tag_t;

  typedef struct packed {
    sl2_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } sl2_l1_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } sl2_mem_req_t;

  typedef struct packed {
    logic write_alloc;
    logic copy_back;
  } sl2_cfg_t;

  typedef struct packed {
    sl2_cfg_t cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sl2_apb_t;

  typedef struct packed {
    sl2_state_t state;
    sl2_l1_req_t req;
    logic ready;
    logic [BEAT_W-1:0] beat;
    logic [IDX_W-1:0] init_idx;
    logic refill;
    sl2_mem_req_t mem;
    logic rvalid;
    logic [31:0] rdata;
    logic done;
    logic [31:0] hits;
    logic [31:0] misses;
  } sl2_core_t;

  function automatic logic [IDX_W-1:0] sl2_idx_of(input logic [ADDR_W-1:0] a);
    return a[OFF_W +: IDX_W];
  endfunction

  function automatic logic [TAG_W-1:0] sl2_tag_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: TAG_W];
  endfunction

  function automatic logic [SUB_W-1:0] sl2_sub_of(input logic [ADDR_W-1:0] a);
    return a[SUB_LSB +: SUB_W];
  endfunction
endpackage

// ### rtl/sl2_apb_regs.sv
// APB register slave holding the cache policy and showing cache status
`timescale 1ns/100ps
`include "sl2_regs.svh"
module sl2_apb_regs import sl2_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SL2_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  output sl2_cfg_t cfg,
  input wire logic busy,
  input wire logic [31:0] hits,
  input wire logic [31:0] misses
);
  sl2_apb_t r;
  sl2_apb_t n;

  // Answer prepared in setup, so every access takes exactly one access cycle
  always_comb begin
    n = r;
    n.pready = 1'b0;
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = 32'h0;
      case (paddr)
        `SL2_CTRL_OFF: n.prdata = {30'h0, r.cfg.write_alloc, r.cfg.copy_back};
        `SL2_STAT_OFF: n.prdata = {31'h0, busy};
        `SL2_HITS_OFF: n.prdata = hits;
        `SL2_MISS_OFF: n.prdata = misses;
        default: n.pslverr = 1'b1;
      endcase
    end
    // Level 2 policy is its own register, free of the level 1 policy
    if (psel && penable && r.pready && pwrite && paddr == `SL2_CTRL_OFF) begin
      n.cfg.copy_back = pwdata[`SL2_CTRL_CB_BIT];
      n.cfg.write_alloc = pwdata[`SL2_CTRL_WA_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{cfg: `SL2_CTRL_RST, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign cfg = r.cfg;
endmodule

// ### rtl/sl2_cache.sv
// Direct-mapped sector level 2 cache controller with selectable write policy
// Behaviour
// - Write-through: a store hit updates the cache and goes to memory at once.
// - Write-through: the requester stalls until the memory write completes.
// - Copy-back: a store hit updates only the cache; memory written on dirty eviction.
// - Each tag entry keeps dirty bits, set by copy-back stores, checked at eviction.
// - Write allocate on: a store miss fills the line, then applies the store.
// - Write allocate off: a store miss goes to memory only, cache untouched.
// - Fills and write-backs to memory always move one whole line.
// - Whole lines toward memory on fill and eviction, single words on stores; sub-blocks toward level 1.
// - Sub-blocks per line is a power of two, picked by plain address bits.
// - Each sub-block has valid, dirty and level 1 presence bits.
// - Tag width is 32 minus index bits minus byte offset bits.
// - Line size is a parameter: 16, 32, 64 or 128 bytes.
// - Level 2 policy is chosen independently of the level 1 policy.
`timescale 1ns/100ps
`include "sl2_regs.svh"
module sl2_cache import sl2_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SL2_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Level 1 request
  input wire logic l1_req_valid,
  input wire sl2_l1_req_t l1_req,
  output logic l1_req_ready,
  // Level 1 answer
  output logic l1_rvalid,
  output logic [31:0] l1_rdata,
  output logic l1_done,
  // Main memory, one word per request
  output sl2_mem_req_t mem_out,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  sl2_core_t r;
  sl2_core_t n;
  sl2_cfg_t cfg;
  sl2_tag_t tag_mem [0:NLINES-1];
  logic [31:0] data_mem [0:NLINES*LINE_WORDS-1];
  logic [IDX_W-1:0] ridx;
  logic [TAG_W-1:0] rtag;
  logic [SUB_W-1:0] rsub;
  sl2_tag_t ent;
  logic tag_match;
  logic hit;
  logic line_dirty;
  logic tag_we;
  logic [IDX_W-1:0] tag_wi;
  sl2_tag_t tag_wd;
  logic data_we;
  logic [IDX_W+BEAT_W-1:0] data_wi;
  logic [31:0] data_wd;

  sl2_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg),
    .busy(r.state != SL2_IDLE),
    .hits(r.hits),
    .misses(r.misses)
  );

  // Index, tag and sub-block straight from address bits
  assign ridx = sl2_idx_of(r.req.addr);
  assign rtag = sl2_tag_of(r.req.addr);
  assign rsub = sl2_sub_of(r.req.addr);
  assign ent = tag_mem[ridx];
  assign tag_match = ent.tag == rtag;
  assign hit = tag_match && ent.valid[rsub];
  // Lines are only ever filled whole, so a dirty line is wholly valid
  assign line_dirty = |ent.dirty;

  always_comb begin
    n = r;
    n.rvalid = 1'b0;
    n.done = 1'b0;
    tag_we = 1'b0;
    tag_wi = ridx;
    tag_wd = ent;
    data_we = 1'b0;
    data_wi = {ridx, r.req.addr[2 +: BEAT_W]};
    data_wd = r.req.wdata;
    case (r.state)
      SL2_INIT: begin
        // Tag store has no reset, so clear one entry per cycle
        tag_we = 1'b1;
        tag_wi = r.init_idx;
        tag_wd = '0;
        n.init_idx = r.init_idx + IDX_W'(1);
        if (&r.init_idx) begin
          n.state = SL2_IDLE;
        end
      end
      SL2_IDLE: begin
        if (l1_req_valid && r.ready) begin
          n.req = l1_req;
          n.refill = 1'b0;
          n.state = SL2_CHECK;
        end
      end
      SL2_CHECK: begin
        if (r.req.op == SL2_OP_DROP) begin
          // Level 1 gave up its copy of the sub-block
          if (tag_match) begin
            tag_we = 1'b1;
            tag_wd.incl[rsub] = 1'b0;
          end
          n.done = 1'b1;
          n.state = SL2_IDLE;
        end else if (hit) begin
          if (!r.refill) begin
            n.hits = r.hits + 32'h1;
          end
          if (r.req.op == SL2_OP_READ) begin
            tag_we = 1'b1;
            tag_wd.incl[rsub] = 1'b1;
            n.beat = '0;
            n.state = SL2_SEND;
          end else begin
            data_we = 1'b1;
            if (cfg.copy_back) begin
              tag_we = 1'b1;
              tag_wd.dirty[rsub] = 1'b1;
              n.done = 1'b1;
              n.state = SL2_IDLE;
            end else begin
              n.mem = '{req: 1'b1, we: 1'b1, addr: r.req.addr, wdata: r.req.wdata};
              n.state = SL2_MEMW;
            end
          end
        end else begin
          n.misses = r.misses + 32'h1;
          if (r.req.op == SL2_OP_WRITE && !cfg.write_alloc) begin
            n.mem = '{req: 1'b1, we: 1'b1, addr: r.req.addr, wdata: r.req.wdata};
            n.state = SL2_MEMW;
          end else begin
            n.refill = 1'b1;
            n.beat = '0;
            n.state = line_dirty ? SL2_WB : SL2_FILL;
          end
        end
      end
      SL2_WB: begin
        if (!r.mem.req) begin
          n.mem = '{req: 1'b1, we: 1'b1, addr: {ent.tag, ridx, r.beat, 2'b00},
                    wdata: data_mem[{ridx, r.beat}]};
        end else if (mem_ack) begin
          n.mem.req = 1'b0;
          n.beat = r.beat + BEAT_W'(1);
          if (r.beat == LAST_BEAT) begin
            n.beat = '0;
            n.state = SL2_FILL;
          end
        end
      end
      SL2_FILL: begin
        if (!r.mem.req) begin
          n.mem = '{req: 1'b1, we: 1'b0, addr: {rtag, ridx, r.beat, 2'b00},
                    wdata: 32'h0};
        end else if (mem_ack) begin
          n.mem.req = 1'b0;
          data_we = 1'b1;
          data_wi = {ridx, r.beat};
          data_wd = mem_rdata;
          n.beat = r.beat + BEAT_W'(1);
          if (r.beat == LAST_BEAT) begin
            tag_we = 1'b1;
            tag_wd = '{tag: rtag, valid: '1, dirty: '0, incl: '0};
            n.state = SL2_CHECK;
          end
        end
      end
      SL2_SEND: begin
        // One level 1 line leaves as one burst of words
        n.rvalid = 1'b1;
        n.rdata = data_mem[{ridx, rsub, r.beat[WSEL_W-1:0]}];
        n.beat = r.beat + BEAT_W'(1);
        if (r.beat[WSEL_W-1:0] == SUB_LAST) begin
          n.done = 1'b1;
          n.state = SL2_IDLE;
        end
      end
      SL2_MEMW: begin
        if (mem_ack) begin
          n.mem.req = 1'b0;
          n.done = 1'b1;
          n.state = SL2_IDLE;
        end
      end
      default: n.state = SL2_IDLE;
    endcase
    n.ready = n.state == SL2_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Arrays are too large for reset; tags are cleared in SL2_INIT, data is don't-care until filled
  always_ff @(posedge pclk) begin
    if (tag_we) begin
      tag_mem[tag_wi] <= tag_wd;
    end
    if (data_we) begin
      data_mem[data_wi] <= data_wd;
    end
  end

  assign l1_req_ready = r.ready;
  assign l1_rvalid = r.rvalid;
  assign l1_rdata = r.rdata;
  assign l1_done = r.done;
  assign mem_out = r.mem;

  logic wr_hit;
  logic wr_miss;
  logic rd_hit;
  logic fill_last;
  assign wr_hit = r.state == SL2_CHECK && r.req.op == SL2_OP_WRITE && hit;
  assign wr_miss = r.state == SL2_CHECK && r.req.op == SL2_OP_WRITE && !hit;
  assign rd_hit = r.state == SL2_CHECK && r.req.op == SL2_OP_READ && hit;
  assign fill_last = r.state == SL2_FILL && r.mem.req && mem_ack && r.beat == LAST_BEAT;

  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sub_burst;
    l1_rvalid [*4] ##1 !l1_rvalid;
  endsequence

  property p_wt_forward;
    wr_hit && !cfg.copy_back |=> mem_out.req && mem_out.we && mem_out.addr == $past(r.req.addr);
  endproperty
  a_wt_forward: assert property (p_wt_forward) else $error("store hit not forwarded");

  property p_wt_stall;
    r.state == SL2_MEMW && !mem_ack |=> !l1_done && !l1_req_ready;
  endproperty
  a_wt_stall: assert property (p_wt_stall) else $error("requester released early");

  property p_cb_local;
    wr_hit && cfg.copy_back |=> l1_done && !mem_out.req;
  endproperty
  a_cb_local: assert property (p_cb_local) else $error("copy-back store hit memory");

  property p_cb_dirty;
    wr_hit && cfg.copy_back |=> tag_mem[ridx].dirty[rsub];
  endproperty
  a_cb_dirty: assert property (p_cb_dirty) else $error("dirty bit not set");

  property p_alloc;
    wr_miss && cfg.write_alloc |=> r.state == SL2_WB || r.state == SL2_FILL;
  endproperty
  a_alloc: assert property (p_alloc) else $error("store miss not allocated");

  property p_no_alloc;
    wr_miss && !cfg.write_alloc |=> r.state == SL2_MEMW && mem_out.we && !r.refill;
  endproperty
  a_no_alloc: assert property (p_no_alloc) else $error("store miss touched cache");

  property p_fill_line;
    $rose(r.state == SL2_FILL) |-> r.beat == '0 ##0 !fill_last;
  endproperty
  a_fill_line: assert property (p_fill_line) else $error("fill not from line start");

  property p_sub_burst;
    $rose(l1_rvalid) |-> s_sub_burst;
  endproperty
  a_sub_burst: assert property (p_sub_burst) else $error("sub-block burst length wrong");

  property p_incl;
    rd_hit |=> tag_mem[ridx].incl[rsub];
  endproperty
  a_incl: assert property (p_incl) else $error("presence bit not set");

  property p_drop;
    r.state == SL2_CHECK && r.req.op == SL2_OP_DROP && tag_match |=> !tag_mem[ridx].incl[rsub];
  endproperty
  a_drop: assert property (p_drop) else $error("presence bit not cleared");

  property p_miss_no_send;
    r.state == SL2_CHECK && r.req.op == SL2_OP_READ && !hit |=> r.state != SL2_SEND;
  endproperty
  a_miss_no_send: assert property (p_miss_no_send) else $error("data sent on miss");

  property p_fill_clean;
    fill_last |=> tag_mem[ridx].valid == '1 && tag_mem[ridx].dirty == '0 && r.state == SL2_CHECK;
  endproperty
  a_fill_clean: assert property (p_fill_clean) else $error("filled line not clean");
endmodule

// ### tb/sl2_mem_model.sv
// Main memory model answering one word per request, promptly or slowly
`timescale 1ns/100ps
module sl2_mem_model import sl2_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller side
  input wire sl2_mem_req_t mem_out,
  input wire logic slow,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] wait_cnt;
  int rd_n = 0;
  int wr_n = 0;

  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'h3c3c_0000;
  endfunction

  // Data line wiggles while no request is pending so stale data never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_cnt <= 2'h0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_out.req && !mem_ack) begin
        if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
          mem_ack <= 1'b1;
          wait_cnt <= 2'h0;
          if (mem_out.we) begin
            mem[mem_out.addr] = mem_out.wdata;
            wr_n <= wr_n + 1;
          end else begin
            mem_rdata <= peek(mem_out.addr);
            rd_n <= rd_n + 1;
          end
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end else if (!mem_ack) begin
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule

// ### tb/test_sl2_cache.sv
// Self-checking testbench for the level 2 cache controller
`timescale 1ns/100ps
module test_sl2_cache import sl2_pkg::*; ;
  typedef struct {logic [1:0] ctrl; sl2_op_t op; logic [31:0] addr; logic [31:0] wdata;
    int nrd; int nwr; int mchk;} sl2_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic l1_req_valid = 1'b0;
  sl2_l1_req_t l1_req = '0;
  logic l1_req_ready;
  logic l1_rvalid;
  logic [31:0] l1_rdata;
  logic l1_done;
  sl2_mem_req_t mem_out;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic slow = 1'b0;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] shad [logic [31:0]];
  // Copy-back on bit 0, write allocate on bit 1; mchk 1 memory new, 2 memory old
  sl2_row_t rows [12] = '{
    '{2'h0, SL2_OP_WRITE, 32'h0000_1040, 32'h1111_1111, 0, 1, 1},
    '{2'h0, SL2_OP_READ, 32'h0000_1040, 32'h0, 16, 0, 0},
    '{2'h0, SL2_OP_READ, 32'h0000_1040, 32'h0, 0, 0, 0},
    '{2'h0, SL2_OP_WRITE, 32'h0000_1044, 32'h2222_2222, 0, 1, 1},
    '{2'h1, SL2_OP_WRITE, 32'h0000_1048, 32'h3333_3333, 0, 0, 2},
    '{2'h1, SL2_OP_READ, 32'h0000_1040, 32'h0, 0, 0, 0},
    '{2'h1, SL2_OP_READ, 32'h0004_1040, 32'h0, 16, 16, 0},
    '{2'h3, SL2_OP_WRITE, 32'h0000_2080, 32'h4444_4444, 16, 0, 2},
    '{2'h3, SL2_OP_READ, 32'h0000_2080, 32'h0, 0, 0, 0},
    '{2'h3, SL2_OP_READ, 32'h0000_2090, 32'h0, 0, 0, 0},
    '{2'h3, SL2_OP_DROP, 32'h0000_2080, 32'h0, 0, 0, 0},
    '{2'h2, SL2_OP_WRITE, 32'h0000_3000, 32'h5555_5555, 16, 1, 1}};

  always #4 pclk = ~pclk;

  sl2_cache sl2_cache_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .l1_req_valid(l1_req_valid), .l1_req(l1_req),
    .l1_req_ready(l1_req_ready), .l1_rvalid(l1_rvalid), .l1_rdata(l1_rdata),
    .l1_done(l1_done), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  sl2_mem_model sl2_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_out(mem_out),
    .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  function automatic logic [31:0] expw(input logic [31:0] a);
    return shad.exists(a) ? shad[a] : a ^ 32'h3c3c_0000;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk("register read", exp, rd);
    chk("register error", {31'h0, eerr}, {31'h0, e});
  endtask

  task automatic l1op(input sl2_op_t op, input logic [31:0] a, input logic [31:0] d,
      output int nw, output int mr, output int mw);
    int r0;
    int w0;
    nw = 0;
    @(posedge pclk);
    l1_req_valid <= 1'b1;
    l1_req <= '{op: op, addr: a, wdata: d};
    @(posedge pclk);
    while (l1_req_ready !== 1'b1) begin
      @(posedge pclk);
    end
    r0 = sl2_mem_model_inst.rd_n;
    w0 = sl2_mem_model_inst.wr_n;
    l1_req_valid <= 1'b0;
    @(posedge pclk);
    chk("ready after take", 32'h0, {31'h0, l1_req_ready});
    // This wait ends on l1_done, or at the bench timeout
    do begin
      @(posedge pclk);
      if (l1_rvalid === 1'b1) begin
        chk("read word", expw({a[31:4], 4'h0} + 32'(4 * nw)), l1_rdata);
        nw++;
      end
    end while (l1_done !== 1'b1);
    mr = sl2_mem_model_inst.rd_n - r0;
    mw = sl2_mem_model_inst.wr_n - w0;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    int nw;
    int mr;
    int mw;
    logic [31:0] old;
    logic [31:0] rd;
    logic e;
    repeat (6) @(posedge pclk);
    chk("ready in reset", 32'h0, {31'h0, l1_req_ready});
    chk("memory request in reset", 32'h0, {31'h0, mem_out.req});
    presetn <= 1'b1;
    rchk(`SL2_CTRL_OFF, 32'h0, 1'b0);
    rchk(12'h010, 32'h0, 1'b1);
    while (l1_req_ready !== 1'b1) @(posedge pclk);
    for (int i = 0; i < 12; i++) begin
      slow <= i[0];
      apb(1'b1, `SL2_CTRL_OFF, {30'h0, rows[i].ctrl}, rd, e);
      old = expw(rows[i].addr);
      l1op(rows[i].op, rows[i].addr, rows[i].wdata, nw, mr, mw);
      chk("words returned", (rows[i].op == SL2_OP_READ) ? 32'h4 : 32'h0, 32'(nw));
      chk("memory reads", 32'(rows[i].nrd), 32'(mr));
      chk("memory writes", 32'(rows[i].nwr), 32'(mw));
      if (rows[i].op == SL2_OP_WRITE) shad[rows[i].addr] = rows[i].wdata;
      if (rows[i].mchk != 0) begin
        old = (rows[i].mchk == 1) ? rows[i].wdata : old;
        chk("memory word", old, sl2_mem_model_inst.peek(rows[i].addr));
      end
    end
    chk("written back", 32'h3333_3333, sl2_mem_model_inst.peek(32'h0000_1048));
    rchk(`SL2_STAT_OFF, 32'h0, 1'b0);
    // Refill re-checks count only the miss
    rchk(`SL2_HITS_OFF, 32'h6, 1'b0);
    rchk(`SL2_MISS_OFF, 32'h5, 1'b0);
    // Reset in the middle of a line fill
    @(posedge pclk);
    l1_req_valid <= 1'b1;
    l1_req <= '{op: SL2_OP_READ, addr: 32'h0000_5000, wdata: 32'h0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b0;
    l1_req_valid <= 1'b0;
    @(posedge pclk);
    chk("memory request after reset", 32'h0, {31'h0, mem_out.req});
    chk("ready after reset", 32'h0, {31'h0, l1_req_ready});
    presetn <= 1'b1;
    rchk(`SL2_CTRL_OFF, 32'h0, 1'b0);
    // Reset drops the dirty line at 0x2080, so this read refills without write-back
    l1op(SL2_OP_READ, 32'h0000_2090, 32'h0, nw, mr, mw);
    chk("words after reset", 32'h4, 32'(nw));
    chk("reads after reset", 32'h10, 32'(mr));
    chk("writes after reset", 32'h0, 32'(mw));
    report_and_stop();
  end
endmodule
